/* hdl/fpp_defines.vh */
`ifndef FPP_DEFINES_VH
`define FPP_DEFINES_VH
// fuse high byte fields
`define FPP_FH_RSTDIS 7
`define FPP_FH_WATCHDOG_FORCED_ON_FUSE 6
`define FPP_FH_SERPROG 5
`define FPP_FH_OSCOPT 4
`define FPP_FH_EEKEEP 3
`define FPP_FH_BOOT_HI 2
`define FPP_FH_BOOT_LO 1
`define FPP_FH_RSTVEC 0
// fuse low byte fields
`define FPP_FL_BODLVL 7
`define FPP_FL_BROWNOUT_ON_FUSE 6
`define FPP_FL_SUT_HI 5
`define FPP_FL_SUT_LO 4
`define FPP_FL_CKS_HI 3
`define FPP_FL_CKS_LO 0
// shipped values, 0 = programmed
`define FPP_FUSE_HIGH_RESET 8'hd9
`define FPP_FUSE_LOW_RESET 8'he1
`define FPP_CKSEL_RC_1MHZ 4'h1
`define FPP_LOCK_RESET 8'hff
// strobe action codes
`define FPP_ACT_ADDR 2'h0
`define FPP_ACT_DATA 2'h1
`define FPP_ACT_CMD 2'h2
`define FPP_ACT_IDLE 2'h3
// command bytes
`define FPP_CMD_ERASE 8'h80
`define FPP_CMD_WR_FUSE 8'h40
`define FPP_CMD_WR_LOCK 8'h20
`define FPP_CMD_WR_FLASH 8'h10
`define FPP_CMD_WR_EE 8'h11
`define FPP_CMD_RD_SIG 8'h08
`define FPP_CMD_RD_FUSE 8'h04
`define FPP_CMD_RD_FLASH 8'h02
`define FPP_CMD_RD_EE 8'h03
// geometry
`define FPP_FLASH_WORDS 4096
`define FPP_EE_BYTES 512
// timing
`define FPP_CLK_MHZ 100
`define FPP_PROG_NS 50
`define FPP_PROG_CYC ((`FPP_PROG_NS * `FPP_CLK_MHZ) / 1000)
`endif

/* hdl/fpp_pin_sync.v */
`timescale 1ns/10ps
`include "fpp_defines.vh"
module fpp_pin_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] pin_in,
    output reg [W-1:0] level
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    // three stages; a change counts once the last two agree
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            level <= INIT;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level <= (s2_reg & s3_reg) | (level & (s2_reg | s3_reg));
        end
    end
endmodule

/* hdl/fpp_port.v */
`timescale 1ns/10ps
`include "fpp_defines.vh"
module fpp_port #(
    parameter [7:0] SIG_BYTE0 = 8'ha5,  // arbitrary identity value
    parameter [7:0] SIG_BYTE1 = 8'h5a,  // arbitrary identity value
    parameter [7:0] SIG_BYTE2 = 8'h3c,  // arbitrary identity value
    parameter [31:0] CAL_BYTES = 32'h80808080  // 8,4,2,1 MHz trims, high to low
) (
    input wire CORE_CLK,
    input wire RST,
    input wire PROG_MODE,
    input wire SERIAL_PATH,
    input wire XTAL1,
    input wire WR_N,
    input wire OE_N,
    input wire BYTE_SELECT_FIRST,
    input wire BYTE_SELECT_SECOND,
    input wire STROBE_ACTION_BIT0,
    input wire STROBE_ACTION_BIT1,
    input wire PAGE_LOAD_STROBE,
    input wire [7:0] DATA_IN,
    output reg [7:0] DATA_OUT,
    output reg DATA_OE,
    output reg READY_BUSY_OUT,
    output reg [7:0] FUSE_HIGH_ACTIVE,
    output reg [7:0] FUSE_LOW_ACTIVE,
    output reg EEPROM_KEEP_ON_ERASE,
    output reg INTERNAL_RC_1MHZ,
    output reg [7:0] OSC_TRIM_REGISTER
);
    localparam ST_IDLE = 3'b001;
    localparam ST_BUSY = 3'b010;
    localparam ST_DONE = 3'b100;
    // busy span minus one, cut to the counter width on purpose
    localparam [31:0] PROG_CYC_M1 = `FPP_PROG_CYC - 1;

    wire xtal_s, wr_n_s, oe_n_s, bs1_s, bs2_s, xa0_s, xa1_s, page_load_strobe_s;
    wire [7:0] din_s;
    reg xtal_d_reg, wr_n_d_reg, oe_n_d_reg;
    reg [7:0] cmd_reg, addr_lo_reg, addr_hi_reg, data_lo_reg, data_hi_reg;
    reg [7:0] fuse_high_byte, fuse_low_byte, lock_reg;
    reg [15:0] flash_mem [0:`FPP_FLASH_WORDS-1];
    reg [7:0] ee_mem [0:`FPP_EE_BYTES-1];
    reg [2:0] state_reg, state_next;
    reg [7:0] cnt_reg;
    reg prog_d_reg;
    reg trim_loaded_reg;
    reg [7:0] rd_byte;
    reg [15:0] fl_word;
    integer i;

    // data and control pins share one chain; wr_n and oe_n start idle high out of reset, the other pins low
    fpp_pin_sync #(.W(16), .INIT(16'h0060)) u_sync (
        .clk(CORE_CLK),
        .rst(RST),
        .pin_in({DATA_IN, XTAL1, WR_N, OE_N, BYTE_SELECT_FIRST, BYTE_SELECT_SECOND,
                 STROBE_ACTION_BIT0, STROBE_ACTION_BIT1, PAGE_LOAD_STROBE}),
        .level({din_s, xtal_s, wr_n_s, oe_n_s, bs1_s, bs2_s, xa0_s, xa1_s, page_load_strobe_s})
    );

    // page geometry helpers
    // both memories pack the page field above the offset inside the page
    function [11:0] flash_addr;
        input [6:0] page;
        input [4:0] word;
        flash_addr = {page, word};
    endfunction
    function [8:0] ee_addr;
        input [6:0] page;
        input [1:0] byte_i;
        ee_addr = {page, byte_i};
    endfunction

    // edges taken on synchronised copies; a pin glitch sampled on one clock edge only never counts
    wire xtal_rise = xtal_s & ~xtal_d_reg;
    wire wr_fall = ~wr_n_s & wr_n_d_reg;
    wire oe_fall = ~oe_n_s & oe_n_d_reg;
    // flash word address: low nibble of the high address byte, then the low byte
    wire [11:0] fl_a = flash_addr({addr_hi_reg[3:0], addr_lo_reg[7:5]}, addr_lo_reg[4:0]);
    // eeprom byte address: bit 0 of the high address byte, then the low byte
    wire [8:0] ee_a = ee_addr({addr_hi_reg[0], addr_lo_reg[7:2]}, addr_lo_reg[1:0]);
    wire fuse_locked = ~lock_reg[0];

    // edge history of synchronised strobes
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            xtal_d_reg <= 1'b0;
            wr_n_d_reg <= 1'b1;
            oe_n_d_reg <= 1'b1;
            prog_d_reg <= 1'b0;
        end else begin
            xtal_d_reg <= xtal_s;
            wr_n_d_reg <= wr_n_s;
            oe_n_d_reg <= oe_n_s;
            prog_d_reg <= PROG_MODE;
        end
    end

    // action bits on each xtal1 rising edge; registers hold until reloaded
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cmd_reg <= 8'h00;
            addr_lo_reg <= 8'h00;
            addr_hi_reg <= 8'h00;
            data_lo_reg <= 8'h00;
            data_hi_reg <= 8'h00;
        end else if (PROG_MODE && xtal_rise) begin
            case ({xa1_s, xa0_s})
                `FPP_ACT_ADDR: begin
                    if (bs1_s)
                        addr_hi_reg <= din_s;
                    else
                        addr_lo_reg <= din_s;
                end
                `FPP_ACT_DATA: begin
                    if (bs1_s)
                        data_hi_reg <= din_s;
                    else
                        data_lo_reg <= din_s;
                end
                `FPP_ACT_CMD: cmd_reg <= din_s;
                default: ;  // idle code does nothing
            endcase
        end
    end

    // busy timer: one fixed program time per write-class command
    // a second wr strobe while busy is dropped, not queued
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (PROG_MODE && wr_fall) state_next = ST_BUSY;
            ST_BUSY: if (cnt_reg == 8'h00) state_next = ST_DONE;
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 8'h00;
            READY_BUSY_OUT <= 1'b1;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE)
                cnt_reg <= PROG_CYC_M1[7:0];
            else if (cnt_reg != 8'h00)
                cnt_reg <= cnt_reg - 8'h01;
            READY_BUSY_OUT <= (state_next != ST_BUSY);
        end
    end

    // nonvolatile store: fuses, locks, flash, eeprom, written on wr strobe
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            fuse_high_byte <= `FPP_FUSE_HIGH_RESET;
            fuse_low_byte <= `FPP_FUSE_LOW_RESET;
            lock_reg <= `FPP_LOCK_RESET;
        end else if (PROG_MODE && wr_fall && state_reg == ST_IDLE) begin
            case (cmd_reg)
                `FPP_CMD_ERASE: begin
                    // fuse bytes deliberately untouched
                    // arrays clear in one cycle, far quicker than a real cell array
                    lock_reg <= `FPP_LOCK_RESET;
                    for (i = 0; i < `FPP_FLASH_WORDS; i = i + 1)
                        flash_mem[i] <= 16'hffff;
                    if (fuse_high_byte[`FPP_FH_EEKEEP]) begin
                        for (i = 0; i < `FPP_EE_BYTES; i = i + 1)
                            ee_mem[i] <= 8'hff;
                    end
                end
                `FPP_CMD_WR_FUSE: begin
                    if (!fuse_locked) begin
                        if (bs1_s) begin
                            // serial path may not move the serial-enable fuse
                            fuse_high_byte <= SERIAL_PATH ?
                                {data_lo_reg[7:6], fuse_high_byte[5], data_lo_reg[4:0]} :
                                data_lo_reg;
                        end else begin
                            fuse_low_byte <= data_lo_reg;
                        end
                    end
                end
                `FPP_CMD_WR_LOCK: lock_reg <= lock_reg & data_lo_reg;  // only programs
                `FPP_CMD_WR_FLASH: begin
                    if (lock_reg[0])
                        flash_mem[fl_a] <= {data_hi_reg, data_lo_reg};
                end
                `FPP_CMD_WR_EE: begin
                    if (lock_reg[0])
                        ee_mem[ee_a] <= data_lo_reg;
                end
                default: ;
            endcase
        end
    end

    // read mux for oe strobe
    always @* begin
        fl_word = flash_mem[fl_a];
        rd_byte = 8'hff;
        case (cmd_reg)
            `FPP_CMD_RD_SIG: begin
                // identity and trims stay readable whatever the locks say
                if (bs1_s)
                    rd_byte = (addr_lo_reg[7:2] == 6'h00) ? CAL_BYTES[addr_lo_reg[1:0]*8 +: 8]
                                                          : 8'hff;
                else
                    case (addr_lo_reg)
                        8'h00: rd_byte = SIG_BYTE0;
                        8'h01: rd_byte = SIG_BYTE1;
                        8'h02: rd_byte = SIG_BYTE2;
                        default: rd_byte = 8'hff;
                    endcase
            end
            `FPP_CMD_RD_FUSE: begin
                // stored bits: 0 = programmed, 1 = unprogrammed
                if (bs2_s)
                    rd_byte = fuse_high_byte;
                else if (bs1_s)
                    rd_byte = lock_reg;
                else if (SERIAL_PATH)
                    rd_byte = fuse_low_byte;
                else
                    rd_byte = fuse_low_byte;
            end
            `FPP_CMD_RD_FLASH: begin
                if (lock_reg[1] | lock_reg[0])
                    rd_byte = bs1_s ? fl_word[15:8] : fl_word[7:0];
            end
            `FPP_CMD_RD_EE: begin
                if (lock_reg[1] | lock_reg[0])
                    rd_byte = ee_mem[ee_a];
            end
            default: rd_byte = 8'hff;
        endcase
    end

    // data bus driven only while oe held low in programming mode
    // bus follows oe by the sync delay, so the programmer waits before sampling
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            DATA_OUT <= 8'h00;
            DATA_OE <= 1'b0;
        end else begin
            DATA_OE <= PROG_MODE & ~oe_n_s;
            if (PROG_MODE && (oe_fall || !oe_n_s))
                DATA_OUT <= (SERIAL_PATH && cmd_reg == `FPP_CMD_RD_FUSE && bs2_s) ?
                    {rd_byte[7:6], 1'b1, rd_byte[4:0]} : rd_byte;
        end
    end

    // active fuse copies: caught at power-up and programming entry, frozen in mode
    // outside programming mode they track the store, so a change lands on leaving
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            FUSE_HIGH_ACTIVE <= `FPP_FUSE_HIGH_RESET;
            FUSE_LOW_ACTIVE <= `FPP_FUSE_LOW_RESET;
            EEPROM_KEEP_ON_ERASE <= 1'b0;
            INTERNAL_RC_1MHZ <= 1'b1;
            OSC_TRIM_REGISTER <= 8'h00;
            trim_loaded_reg <= 1'b0;
        end else begin
            if (!PROG_MODE || !prog_d_reg) begin
                FUSE_HIGH_ACTIVE <= fuse_high_byte;
                FUSE_LOW_ACTIVE <= fuse_low_byte;
            end
            // keep fuse acts at once, even inside programming mode
            EEPROM_KEEP_ON_ERASE <= ~fuse_high_byte[`FPP_FH_EEKEEP];
            INTERNAL_RC_1MHZ <= (FUSE_LOW_ACTIVE[`FPP_FL_CKS_HI:`FPP_FL_CKS_LO] ==
                                 `FPP_CKSEL_RC_1MHZ);
            // trim register loaded once after reset with the 1MHz value;
            // other frequencies' trims are software's job, not this block's
            if (!trim_loaded_reg) begin
                OSC_TRIM_REGISTER <= CAL_BYTES[7:0];
                trim_loaded_reg <= 1'b1;
            end
        end
    end
endmodule

/* verification/fpp_port_asserts.sv */
`timescale 1ns/10ps
`include "fpp_defines.vh"
module fpp_port_chk #(
    parameter [31:0] CAL_BYTES = 32'h80808080
) (
    input wire CORE_CLK,
    input wire RST,
    input wire PROG_MODE,
    input wire WR_N,
    input wire OE_N,
    input wire DATA_OE,
    input wire READY_BUSY_OUT,
    input wire [7:0] FUSE_HIGH_ACTIVE,
    input wire [7:0] FUSE_LOW_ACTIVE,
    input wire INTERNAL_RC_1MHZ,
    input wire [7:0] OSC_TRIM_REGISTER
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    reg [3:0] oe_hi_reg;
    reg [3:0] busy_reg;
    reg [4:0] wr_age_reg;
    // saturating ages, pins pass a sync chain so edges drift a few cycles
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            oe_hi_reg <= 4'h0;
            busy_reg <= 4'h0;
            wr_age_reg <= 5'h1f;
        end else begin
            oe_hi_reg <= OE_N ? oe_hi_reg + {3'h0, ~&oe_hi_reg} : 4'h0;
            busy_reg <= READY_BUSY_OUT ? 4'h0 : busy_reg + {3'h0, ~&busy_reg};
            wr_age_reg <= !WR_N ? 5'h00 : wr_age_reg + {4'h0, ~&wr_age_reg};
        end
    end
    chk_oe_release: assert property (oe_hi_reg > 4'h7 |-> !DATA_OE)
        else $error("bus driven with output enable high");
    chk_busy_bound: assert property (busy_reg <= `FPP_PROG_CYC + 1)
        else $error("busy held too long");
    chk_busy_cause: assert property ($fell(READY_BUSY_OUT) |-> wr_age_reg < 5'hc)
        else $error("busy without a write pulse");
    chk_high_latched: assert property (PROG_MODE && $past(PROG_MODE) &&
        $past(PROG_MODE, 4) && !$past(RST) |-> $stable(FUSE_HIGH_ACTIVE))
        else $error("high fuse copy moved in programming mode");
    chk_low_latched: assert property (PROG_MODE && $past(PROG_MODE) &&
        $past(PROG_MODE, 4) && !$past(RST) |-> $stable(FUSE_LOW_ACTIVE))
        else $error("low fuse copy moved in programming mode");
    chk_rc_decode: assert property ($stable(FUSE_LOW_ACTIVE) && !$past(RST) |->
        INTERNAL_RC_1MHZ == (FUSE_LOW_ACTIVE[3:0] == `FPP_CKSEL_RC_1MHZ))
        else $error("rc select disagrees with clock source field");
    chk_trim_load: assert property ($fell(RST) |->
        ##[0:2] (OSC_TRIM_REGISTER == CAL_BYTES[7:0]))
        else $error("trim not loaded after reset");
    chk_reset_idle: assert property ($fell(RST) |-> READY_BUSY_OUT && !DATA_OE)
        else $error("not idle after reset");
    cover property ($fell(READY_BUSY_OUT));
    cover property (DATA_OE && PROG_MODE);
    cover property ($fell(RST));
endmodule
bind fpp_port fpp_port_chk #(.CAL_BYTES(CAL_BYTES)) i_fpp_port_chk (
    .CORE_CLK(CORE_CLK), .RST(RST), .PROG_MODE(PROG_MODE), .WR_N(WR_N), .OE_N(OE_N),
    .DATA_OE(DATA_OE), .READY_BUSY_OUT(READY_BUSY_OUT), .FUSE_HIGH_ACTIVE(FUSE_HIGH_ACTIVE),
    .FUSE_LOW_ACTIVE(FUSE_LOW_ACTIVE), .INTERNAL_RC_1MHZ(INTERNAL_RC_1MHZ),
    .OSC_TRIM_REGISTER(OSC_TRIM_REGISTER)
);

/* verification/fpp_prog_model.sv */
`timescale 1ns/10ps
`include "fpp_defines.vh"
module fpp_prog_model (
    input wire clk,
    input wire data_oe,
    input wire [7:0] data_out,
    output reg prog_mode,
    output reg xtal1,
    output reg wr_n,
    output reg oe_n,
    output reg bs1,
    output reg bs2,
    output reg xa0,
    output reg xa1,
    output reg page_load,
    output wire [7:0] data_in
);
    reg drv_reg;
    reg [7:0] byte_reg;
    reg [7:0] last_reg;
    // a released bus shows a changing pattern, never a stale byte
    assign data_in = data_oe ? data_out : (drv_reg ? byte_reg : ~last_reg);
    always @(posedge clk) begin
        last_reg <= data_in;
    end
    initial begin
        {prog_mode, xtal1, bs1, bs2, xa0, xa1, page_load, drv_reg} = 8'h00;
        {wr_n, oe_n} = 2'h3;
        byte_reg = 8'h00;
        last_reg = 8'h00;
    end
    // every level stands 26 cycles, above the minimum pulse width
    task hold;
        begin
            repeat (26) @(negedge clk);
        end
    endtask
    task enter;
        begin
            {page_load, xa1, xa0, bs1} = 4'h0;
            hold;
            prog_mode = 1'b1;
            hold;
        end
    endtask
    task leave;
        begin
            prog_mode = 1'b0;
            hold;
        end
    endtask
    task act(input [1:0] code, input sel, input [7:0] val);
        begin
            {xa1, xa0} = code;
            bs1 = sel;
            byte_reg = val;
            drv_reg = 1'b1;
            hold;
            xtal1 = 1'b1;
            hold;
            xtal1 = 1'b0;
            {xa1, xa0} = `FPP_ACT_IDLE;
            hold;
        end
    endtask
    task wr(input sel);
        begin
            bs1 = sel;
            hold;
            wr_n = 1'b0;
            hold;
            wr_n = 1'b1;
            hold;
        end
    endtask
    // release the bus before asking the device to drive it
    task rd(input sel1, input sel2, output [7:0] q, output o);
        begin
            drv_reg = 1'b0;
            {bs1, bs2} = {sel1, sel2};
            hold;
            oe_n = 1'b0;
            hold;
            q = data_in;
            o = data_oe;
            oe_n = 1'b1;
            hold;
        end
    endtask
endmodule

/* verification/tb_fpp_port.sv */
`timescale 1ns/10ps
`include "fpp_defines.vh"
module tb_fpp_port;
    reg clk;
    reg rst;
    reg serial_path;
    reg [7:0] busy_run;
    integer busy_cycles;
    integer busy_mark;
    localparam integer PROG_CYC = `FPP_PROG_CYC;
    reg o;
    reg [7:0] q;
    reg [39:0] rows [0:9];
    integer mismatches;
    integer checked;
    integer i;
    wire prog_mode, xtal1, wr_n, oe_n, bs1, bs2, xa0, xa1, page_load;
    wire data_oe, ready, keep, rc_1mhz;
    wire [7:0] data_in, data_out, fuse_hi, fuse_lo, trim;
    fpp_port #(
        .SIG_BYTE0(8'h61), .SIG_BYTE1(8'h62), .SIG_BYTE2(8'h63), // arbitrary identity
        .CAL_BYTES(32'h44332211)
    ) i_fpp_port (
        .CORE_CLK(clk), .RST(rst), .PROG_MODE(prog_mode), .SERIAL_PATH(serial_path),
        .XTAL1(xtal1), .WR_N(wr_n), .OE_N(oe_n), .BYTE_SELECT_FIRST(bs1),
        .BYTE_SELECT_SECOND(bs2), .STROBE_ACTION_BIT0(xa0), .STROBE_ACTION_BIT1(xa1),
        .PAGE_LOAD_STROBE(page_load), .DATA_IN(data_in), .DATA_OUT(data_out),
        .DATA_OE(data_oe), .READY_BUSY_OUT(ready), .FUSE_HIGH_ACTIVE(fuse_hi),
        .FUSE_LOW_ACTIVE(fuse_lo), .EEPROM_KEEP_ON_ERASE(keep),
        .INTERNAL_RC_1MHZ(rc_1mhz), .OSC_TRIM_REGISTER(trim)
    );
    fpp_prog_model i_fpp_prog_model (
        .clk(clk), .data_oe(data_oe), .data_out(data_out), .prog_mode(prog_mode),
        .xtal1(xtal1), .wr_n(wr_n), .oe_n(oe_n), .bs1(bs1), .bs2(bs2), .xa0(xa0),
        .xa1(xa1), .page_load(page_load), .data_in(data_in)
    );
    task test_done;
        begin
            if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rdc(input [7:0] c, input [7:0] a, input s1, input s2, input [7:0] e);
        begin
            i_fpp_prog_model.act(`FPP_ACT_CMD, 1'b0, c);
            i_fpp_prog_model.act(`FPP_ACT_ADDR, 1'b0, a);
            i_fpp_prog_model.rd(s1, s2, q, o);
            chk({7'h00, o}, 8'h01);
            chk(q, e);
        end
    endtask
    task wrc(input [7:0] c, input [7:0] d, input s, input k);
        begin
            i_fpp_prog_model.act(`FPP_ACT_CMD, 1'b0, c);
            i_fpp_prog_model.act(`FPP_ACT_DATA, 1'b0, d);
            busy_mark = busy_cycles;
            i_fpp_prog_model.wr(s);
            busy_run = busy_cycles[7:0] - busy_mark[7:0];
            if (k) chk(busy_run, PROG_CYC[7:0]);
            chk({7'h00, ready}, 8'h01);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // counts cycles with ready/busy low; one process owns the counter
    always @(posedge clk) begin
        if (rst) busy_cycles <= 0;
        else if (ready === 1'b0) busy_cycles <= busy_cycles + 1;
    end
    // a whole run needs under 10k cycles
    initial begin
        repeat (30000) @(posedge clk);
        mismatches = mismatches + 1;
        test_done;
    end
    initial begin
        {mismatches, checked} = 64'h0;
        {rst, serial_path} = 2'h2;
        // cmd, addr, first select, second select, expected byte
        rows[0] = 40'h0800000061; rows[1] = 40'h0801000062; rows[2] = 40'h0802000063;
        rows[3] = 40'h0800010011; rows[4] = 40'h0801010022; rows[5] = 40'h0802010033;
        rows[6] = 40'h0803010044; rows[7] = 40'h04000000e1; rows[8] = 40'h04000001d9;
        rows[9] = 40'h04000100ff;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (5) @(negedge clk);
        chk(fuse_hi, `FPP_FUSE_HIGH_RESET);
        chk(fuse_lo, `FPP_FUSE_LOW_RESET);
        chk({7'h00, rc_1mhz}, 8'h01);
        chk(trim, 8'h11);
        chk({6'h00, ready, data_oe}, 8'h02);
        i_fpp_prog_model.enter;
        for (i = 0; i < 10; i = i + 1) begin
            rdc(rows[i][39:32], rows[i][31:24], rows[i][16], rows[i][8], rows[i][7:0]);
        end
        wrc(`FPP_CMD_WR_FUSE, 8'hd1, 1'b1, 1'b1);
        wrc(`FPP_CMD_WR_FUSE, 8'he4, 1'b0, 1'b1);
        rdc(`FPP_CMD_RD_FUSE, 8'h00, 1'b0, 1'b1, 8'hd1);
        rdc(`FPP_CMD_RD_FUSE, 8'h00, 1'b0, 1'b0, 8'he4);
        chk(fuse_hi, `FPP_FUSE_HIGH_RESET);
        chk(fuse_lo, `FPP_FUSE_LOW_RESET);
        chk({7'h00, keep}, 8'h01);
        wrc(`FPP_CMD_ERASE, 8'h00, 1'b0, 1'b1);
        rdc(`FPP_CMD_RD_FUSE, 8'h00, 1'b0, 1'b1, 8'hd1);
        i_fpp_prog_model.act(`FPP_ACT_ADDR, 1'b1, 8'h01);
        i_fpp_prog_model.act(`FPP_ACT_ADDR, 1'b0, 8'h25);
        i_fpp_prog_model.act(`FPP_ACT_DATA, 1'b1, 8'hab);
        wrc(`FPP_CMD_WR_FLASH, 8'hcd, 1'b0, 1'b1);
        rdc(`FPP_CMD_RD_FLASH, 8'h25, 1'b1, 1'b0, 8'hab);
        rdc(`FPP_CMD_RD_FLASH, 8'h25, 1'b0, 1'b0, 8'hcd);
        rdc(`FPP_CMD_RD_FLASH, 8'h05, 1'b0, 1'b0, 8'hff);
        wrc(`FPP_CMD_WR_EE, 8'h5e, 1'b0, 1'b1);
        rdc(`FPP_CMD_RD_EE, 8'h05, 1'b0, 1'b0, 8'h5e);
        wrc(`FPP_CMD_WR_LOCK, 8'hfe, 1'b0, 1'b1);
        wrc(`FPP_CMD_WR_FUSE, 8'h00, 1'b0, 1'b0);
        rdc(`FPP_CMD_RD_FUSE, 8'h00, 1'b0, 1'b0, 8'he4);
        rdc(`FPP_CMD_RD_FUSE, 8'h00, 1'b1, 1'b0, 8'hfe);
        rdc(`FPP_CMD_RD_SIG, 8'h02, 1'b0, 1'b0, 8'h63);
        serial_path = 1'b1;
        rdc(`FPP_CMD_RD_FUSE, 8'h00, 1'b0, 1'b1, 8'hf1);
        serial_path = 1'b0;
        i_fpp_prog_model.leave;
        chk(fuse_hi, 8'hd1);
        chk(fuse_lo, 8'he4);
        chk({7'h00, rc_1mhz}, 8'h00);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (5) @(negedge clk);
        chk(trim, 8'h11);
        chk({6'h00, ready, data_oe}, 8'h02);
        test_done;
    end
endmodule
